// file: pkg/plf_regs.vh
// Constants for the PLL loop-filter configuration register bank.
// Assumes byte-wide register access at the printed addresses.
`ifndef PLF_REGS_VH
`define PLF_REGS_VH
// ==========================================
// Register addresses
`define PLF_ADDR_CTRL 8'h23
`define PLF_ADDR_R2 8'h24
`define PLF_ADDR_C1 8'h25
`define PLF_ADDR_R3 8'h26
`define PLF_ADDR_C3 8'h27
// ==========================================
// Reset values
`define PLF_RST_CTRL 8'h03
`define PLF_RST_R2 8'h28
`define PLF_RST_C1 8'h00
`define PLF_RST_R3 8'h00
`define PLF_RST_C3 8'h00
// ==========================================
// Writable-bit masks (reserved bits excluded, ctrl low bits kept)
`define PLF_MASK_CTRL 8'h77
`define PLF_MASK_R2 8'hFF
`define PLF_MASK_C1 8'h07
`define PLF_MASK_R3 8'h7F
`define PLF_MASK_C3 8'h07
// ==========================================
// Field positions
`define PLF_PHASE_MSB 6
`define PLF_PHASE_LSB 4
`define PLF_C3EN_BIT 2
`define PLF_CTRL_RSV_MSB 1
`define PLF_C1_MSB 2
`define PLF_R3_MSB 6
`define PLF_C3_MSB 2
// ==========================================
// Phase detector band decode: code bit 2 set means 50 MHz detector
`define PLF_PHASE_BAND_BIT 2
`define PLF_PHASE_NONE 3'h0
`endif

// file: design/plf_mask_reg.v
// One 8-bit configuration register with write mask and reload port.
// Assumes the write and reload strobes are synchronous single-cycle pulses.
`timescale 1ns/100ps
module plf_mask_reg #(
  parameter [7:0] RST_VAL = 8'h00, // Value after reset
  parameter [7:0] MASK = 8'hFF // Bits that store data
) (
  input wire clk_sys, // System clock
  input wire rst, // Async reset, active high
  input wire wr_en, // Software write strobe
  input wire [7:0] wr_data, // Software write data
  input wire load_en, // Non-volatile reload strobe
  input wire [7:0] load_data, // Stored non-volatile image
  output reg [7:0] q // Register contents
);
  // ==========================================
  // Storage; reload wins over a software write in the same cycle
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= RST_VAL & MASK;
    end
    else if (load_en)
    begin
      q <= load_data & MASK;
    end
    else if (wr_en)
    begin
      q <= wr_data & MASK;
    end
  end
endmodule // plf_mask_reg

// file: design/plf_config_regs.v
// Top of the PLL loop-filter configuration bank: five byte registers.
// Assumes a byte register port from the serial interface and a stored image source.
`timescale 1ns/100ps
`include "plf_regs.vh"
// Overview of operation
// - Phase offset field bits 6:4, reset zero
// - Codes 1-3 100MHz, 4-7 50MHz detector
// - Bit 2 third-pole enable, reset zero
// - Zero-resistor code 8 bits, reset 0x28
// - First-capacitor code bits 2:0, reset zero
// - Third-resistor code bits 6:0, bit7 reserved
// - Third-capacitor code bits 2:0, reset zero
// - Reload stored image after reset or trigger
module plf_config_regs (
  input wire clk_sys, // System clock, 10 MHz
  input wire rst, // Async reset, active high
  input wire [7:0] reg_addr, // Register address
  input wire reg_wr, // Write strobe, one cycle
  input wire reg_rd, // Read strobe, one cycle
  input wire [7:0] reg_wdata, // Write data
  output reg [7:0] reg_rdata, // Read data, valid cycle after strobe
  output reg reg_rvalid, // Read data valid pulse
  input wire nonvolatile_load_trigger, // Reload request pulse
  input wire [39:0] nv_image, // Stored image, ctrl in low byte
  output reg load_busy, // Reload in progress
  output reg [2:0] charge_pump_phase_offset, // Phase offset code
  output reg phase_band_50mhz, // Selected code uses 50 MHz detector
  output reg phase_offset_active, // Nonzero delay selected
  output reg third_pole_cap_enable, // Third order filter on
  output reg [7:0] zero_resistor_code, // R2 code
  output reg [2:0] first_capacitor_code, // C1 code
  output reg [6:0] third_resistor_code, // R3 code
  output reg [2:0] third_capacitor_code // C3 code
);
  // ==========================================
  // Reload sequencer states, one-hot
  localparam [1:0] ST_IDLE = 2'b01; // Normal access
  localparam [1:0] ST_LOAD = 2'b10; // Copy stored image
  reg [1:0] state; // Current state
  reg [1:0] next_state; // Next state
  reg load_pending; // Trigger latched during load
  wire load_en; // Copy strobe to all registers
  wire wr_ok; // Software write allowed
  wire [7:0] q_ctrl; // Control register
  wire [7:0] q_r2; // Zero-resistor register
  wire [7:0] q_c1; // First-capacitor register
  wire [7:0] q_r3; // Third-resistor register
  wire [7:0] q_c3; // Third-capacitor register
  reg [7:0] next_rdata; // Read mux result
  wire wr_ctrl; // Accepted write to the control byte
  wire wr_r2; // Accepted write to the zero-resistor byte
  wire wr_c1; // Accepted write to the first-capacitor byte
  wire wr_r3; // Accepted write to the third-resistor byte
  wire wr_c3; // Accepted write to the third-capacitor byte
  // Reset images, so the field outputs start where the registers start
  localparam [7:0] RST_CTRL = `PLF_RST_CTRL; // Control byte at reset
  localparam [7:0] RST_C1 = `PLF_RST_C1; // First-capacitor byte at reset
  localparam [7:0] RST_R3 = `PLF_RST_R3; // Third-resistor byte at reset
  localparam [7:0] RST_C3 = `PLF_RST_C3; // Third-capacitor byte at reset

  // ==========================================
  // Address match helper
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign load_en = state[1];
  // Writes are dropped while the image is copied; reload owns the bank
  assign wr_ok = reg_wr & state[0];

  // ==========================================
  // Per-register write strobes; one decode each, so no two bytes share a write
  assign wr_ctrl = wr_ok & hit(reg_addr, `PLF_ADDR_CTRL);
  assign wr_r2 = wr_ok & hit(reg_addr, `PLF_ADDR_R2);
  assign wr_c1 = wr_ok & hit(reg_addr, `PLF_ADDR_C1);
  assign wr_r3 = wr_ok & hit(reg_addr, `PLF_ADDR_R3);
  assign wr_c3 = wr_ok & hit(reg_addr, `PLF_ADDR_C3);

  // ==========================================
  // Sequencer: first cycle after reset release performs the copy
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        // Serve a fresh trigger or one remembered from the last copy
        if (nonvolatile_load_trigger | load_pending)
          next_state = ST_LOAD;
      end
      ST_LOAD:
      begin
        // The copy takes exactly one cycle
        next_state = ST_IDLE;
      end
      default:
      begin
        // Illegal code: recover through a fresh copy of the image
        next_state = ST_LOAD;
      end
    endcase
  end

  // State register; reset enters load so the stored image is applied
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_LOAD;
      load_pending <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // Trigger during a copy is kept and served next, not lost
      load_pending <= nonvolatile_load_trigger & state[1];
    end
  end

  // ==========================================
  // Register instances
  plf_mask_reg #(.RST_VAL(`PLF_RST_CTRL), .MASK(`PLF_MASK_CTRL)) u_ctrl (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_ctrl),
    .wr_data(reg_wdata),
    .load_en(load_en),
    .load_data(nv_image[7:0]),
    .q(q_ctrl)
  );
  plf_mask_reg #(.RST_VAL(`PLF_RST_R2), .MASK(`PLF_MASK_R2)) u_r2 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_r2),
    .wr_data(reg_wdata),
    .load_en(load_en),
    .load_data(nv_image[15:8]),
    .q(q_r2)
  );
  plf_mask_reg #(.RST_VAL(`PLF_RST_C1), .MASK(`PLF_MASK_C1)) u_c1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_c1),
    .wr_data(reg_wdata),
    .load_en(load_en),
    .load_data(nv_image[23:16]),
    .q(q_c1)
  );
  plf_mask_reg #(.RST_VAL(`PLF_RST_R3), .MASK(`PLF_MASK_R3)) u_r3 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_r3),
    .wr_data(reg_wdata),
    .load_en(load_en),
    .load_data(nv_image[31:24]),
    .q(q_r3)
  );
  plf_mask_reg #(.RST_VAL(`PLF_RST_C3), .MASK(`PLF_MASK_C3)) u_c3 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_c3),
    .wr_data(reg_wdata),
    .load_en(load_en),
    .load_data(nv_image[39:32]),
    .q(q_c3)
  );

  // ==========================================
  // Read mux; reserved bits already zero from masks, unmapped reads zero
  always @*
  begin
    next_rdata = 8'h00;
    if (hit(reg_addr, `PLF_ADDR_CTRL))
      next_rdata = q_ctrl;
    else if (hit(reg_addr, `PLF_ADDR_R2))
      next_rdata = q_r2;
    else if (hit(reg_addr, `PLF_ADDR_C1))
      next_rdata = q_c1;
    else if (hit(reg_addr, `PLF_ADDR_R3))
      next_rdata = q_r3;
    else if (hit(reg_addr, `PLF_ADDR_C3))
      next_rdata = q_c3;
  end

  // ==========================================
  // Registered outputs; reads refused during a copy (no valid pulse)
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      load_busy <= 1'b1;
      // Field outputs mirror the reset contents of the bytes
      charge_pump_phase_offset <= RST_CTRL[`PLF_PHASE_MSB:`PLF_PHASE_LSB];
      phase_band_50mhz <= RST_CTRL[`PLF_PHASE_LSB + `PLF_PHASE_BAND_BIT];
      phase_offset_active <= (RST_CTRL[`PLF_PHASE_MSB:`PLF_PHASE_LSB] != `PLF_PHASE_NONE);
      third_pole_cap_enable <= RST_CTRL[`PLF_C3EN_BIT];
      zero_resistor_code <= `PLF_RST_R2;
      first_capacitor_code <= RST_C1[`PLF_C1_MSB:0];
      third_resistor_code <= RST_R3[`PLF_R3_MSB:0];
      third_capacitor_code <= RST_C3[`PLF_C3_MSB:0];
    end
    else
    begin
      // Reads are refused in the copy cycle: no answer, data kept
      reg_rvalid <= reg_rd & state[0];
      if (reg_rd & state[0])
        reg_rdata <= next_rdata;
      // Busy tracks the state itself, high exactly in each copy cycle
      load_busy <= next_state[1];
      charge_pump_phase_offset <= q_ctrl[`PLF_PHASE_MSB:`PLF_PHASE_LSB];
      // Codes 4..7 address the 50 MHz detector table
      phase_band_50mhz <= q_ctrl[`PLF_PHASE_LSB + `PLF_PHASE_BAND_BIT];
      phase_offset_active <= (q_ctrl[`PLF_PHASE_MSB:`PLF_PHASE_LSB] != `PLF_PHASE_NONE);
      // Default zero keeps second order, the preferred setup
      third_pole_cap_enable <= q_ctrl[`PLF_C3EN_BIT];
      zero_resistor_code <= q_r2;
      first_capacitor_code <= q_c1[`PLF_C1_MSB:0];
      third_resistor_code <= q_r3[`PLF_R3_MSB:0];
      third_capacitor_code <= q_c3[`PLF_C3_MSB:0];
    end
  end
endmodule // plf_config_regs

// file: verif/plf_regs_chk_sva.sv
// Checker for the loop-filter register bank, watching its top-level ports only.
// Assumes it is bound onto plf_config_regs with matching port names.
`timescale 1ns/100ps
`include "plf_regs.vh"
module plf_regs_chk (
  input wire clk_sys, input wire rst, input wire [7:0] reg_addr, input wire reg_wr, input wire reg_rd,
  input wire [7:0] reg_wdata, input wire [7:0] reg_rdata, input wire reg_rvalid,
  input wire nonvolatile_load_trigger, input wire [39:0] nv_image, input wire load_busy,
  input wire [2:0] charge_pump_phase_offset, input wire phase_band_50mhz, input wire phase_offset_active,
  input wire third_pole_cap_enable, input wire [7:0] zero_resistor_code, input wire [2:0] first_capacitor_code,
  input wire [6:0] third_resistor_code, input wire [2:0] third_capacitor_code
);
  // ==========
  // One clock domain, so clocking and reset are declared once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Accepted write: strobes during a reload are dropped, so excluded
  sequence s_wr(a);
    reg_wr && reg_addr == a && !load_busy;
  endsequence
  // ==========
  // Field outputs trail the stored byte by one cycle
  property p_phase; s_wr(`PLF_ADDR_CTRL) |-> ##2 charge_pump_phase_offset == $past(reg_wdata[6:4], 2); endproperty
  a_phase: assert property (p_phase) else $error("phase offset output wrong");
  property p_band; phase_band_50mhz == charge_pump_phase_offset[2] && phase_offset_active == (|charge_pump_phase_offset); endproperty
  a_band: assert property (p_band) else $error("phase band decode wrong");
  property p_c3en; s_wr(`PLF_ADDR_CTRL) |-> ##2 third_pole_cap_enable == $past(reg_wdata[2], 2); endproperty
  a_c3en: assert property (p_c3en) else $error("third pole enable wrong");
  property p_r2; s_wr(`PLF_ADDR_R2) |-> ##2 zero_resistor_code == $past(reg_wdata, 2); endproperty
  a_r2: assert property (p_r2) else $error("zero resistor code wrong");
  property p_c1; s_wr(`PLF_ADDR_C1) |-> ##2 first_capacitor_code == $past(reg_wdata[2:0], 2); endproperty
  a_c1: assert property (p_c1) else $error("first capacitor code wrong");
  // Reserved top bit must never come back set
  property p_r3; reg_rd && reg_addr == `PLF_ADDR_R3 && !load_busy |=> reg_rvalid && !reg_rdata[7]; endproperty
  a_r3: assert property (p_r3) else $error("third resistor read wrong");
  property p_c3; s_wr(`PLF_ADDR_C3) |-> ##2 third_capacitor_code == $past(reg_wdata[2:0], 2); endproperty
  a_c3: assert property (p_c3) else $error("third capacitor code wrong");
  // Reload: one busy cycle, then the stored image reaches the outputs
  property p_load;
    nonvolatile_load_trigger && !load_busy |=> load_busy ##1 !load_busy ##1 zero_resistor_code == $past(nv_image[15:8], 2);
  endproperty
  a_load: assert property (p_load) else $error("reload sequence wrong");
  c_wr: cover property (s_wr(`PLF_ADDR_R2));
  c_rd: cover property (reg_rvalid);
  c_ld: cover property (load_busy ##1 !load_busy);
  c_ld2: cover property (load_busy ##1 !load_busy ##1 load_busy);
endmodule // plf_regs_chk
bind plf_config_regs plf_regs_chk plf_regs_chk_i (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .nonvolatile_load_trigger(nonvolatile_load_trigger),
  .nv_image(nv_image), .load_busy(load_busy), .charge_pump_phase_offset(charge_pump_phase_offset),
  .phase_band_50mhz(phase_band_50mhz), .phase_offset_active(phase_offset_active),
  .third_pole_cap_enable(third_pole_cap_enable), .zero_resistor_code(zero_resistor_code),
  .first_capacitor_code(first_capacitor_code), .third_resistor_code(third_resistor_code),
  .third_capacitor_code(third_capacitor_code));

// file: verif/test_plf_config_regs.sv
// Self-checking bench for the loop-filter register bank.
// Assumes read answers come one cycle after the strobe, fields one more.
`timescale 1ns/100ps
`include "plf_regs.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_plf_config_regs;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, nonvolatile_load_trigger = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, exp_v;
  logic [39:0] nv_image = 0;
  wire [7:0] reg_rdata, zero_resistor_code;
  wire reg_rvalid, load_busy, phase_band_50mhz, phase_offset_active, third_pole_cap_enable;
  wire [2:0] charge_pump_phase_offset, first_capacitor_code, third_capacitor_code;
  wire [6:0] third_resistor_code;
  int err_count = 0, checked = 0;
  logic [7:0] exp_q[$];
  logic [7:0] adr[5] = '{`PLF_ADDR_CTRL, `PLF_ADDR_R2, `PLF_ADDR_C1, `PLF_ADDR_R3, `PLF_ADDR_C3};
  logic [7:0] msk[5] = '{`PLF_MASK_CTRL, `PLF_MASK_R2, `PLF_MASK_C1, `PLF_MASK_R3, `PLF_MASK_C3};
  always #50 clk_sys = ~clk_sys;
  plf_config_regs plf_config_regs_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .nonvolatile_load_trigger(nonvolatile_load_trigger),
    .nv_image(nv_image), .load_busy(load_busy), .charge_pump_phase_offset(charge_pump_phase_offset),
    .phase_band_50mhz(phase_band_50mhz), .phase_offset_active(phase_offset_active),
    .third_pole_cap_enable(third_pole_cap_enable), .zero_resistor_code(zero_resistor_code),
    .first_capacitor_code(first_capacitor_code), .third_resistor_code(third_resistor_code),
    .third_capacitor_code(third_capacitor_code));
  // ==========
  // Bus tasks: drive at the falling edge, one strobe per cycle
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b10, a, d};
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr} = {2'b01, a};
    exp_q.push_back(e);
  endtask
  task automatic idle(input int n);
    repeat (n) begin @(negedge clk_sys); {reg_wr, reg_rd} = 2'b00; end
  endtask
  // Reads back every register; reserved bits expected as zero
  task automatic rd_all(input logic [39:0] img);
    for (int i = 0; i < 5; i++) rd(adr[i], img[8*i +: 8] & msk[i]);
    idle(3);
  endtask
  // Answer monitor: an answer with no read pending is itself a mismatch
  always @(negedge clk_sys)
    if (reg_rvalid === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK("rdata", exp_v, reg_rdata)
    end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin #(5000 * 100); err_count++; conclude; end
  // ==========
  initial begin
    logic [39:0] img;
    logic [7:0] d;
    void'($urandom(39233));
    nv_image = {8'($urandom), 32'($urandom)};
    repeat (16) @(posedge clk_sys);
    `CHK("r2rst", `PLF_RST_R2, zero_resistor_code)
    `CHK("busyrst", 1'b1, load_busy)
    `CHK("ctrlrst", 4'h0, {charge_pump_phase_offset, third_pole_cap_enable})
    `CHK("lowrst", 13'h0, {first_capacitor_code, third_resistor_code, third_capacitor_code})
    @(negedge clk_sys) rst = 0;
    idle(2);
    rd_all(nv_image);
    $display("test reset done");
    img = nv_image;
    for (int k = 0; k < 10; k++) begin
      d = 8'($urandom);
      wr(adr[k % 5], d);
      img[8*(k % 5) +: 8] = d;
    end
    idle(2);
    `CHK("r2", img[15:8], zero_resistor_code)
    `CHK("c1", img[18:16], first_capacitor_code)
    `CHK("r3", img[30:24], third_resistor_code)
    `CHK("c3", img[34:32], third_capacitor_code)
    rd_all(img);
    rd(8'h28, 8'h00);
    wr(8'h22, 8'hFF);
    idle(2);
    $display("test access done");
    for (int c = 0; c < 8; c++) begin
      wr(`PLF_ADDR_CTRL, {1'b0, 3'(c), 1'b0, 1'(c), 2'h3});
      idle(2);
      `CHK("phase", 3'(c), charge_pump_phase_offset)
      `CHK("band", {c >= 4, c != 0}, {phase_band_50mhz, phase_offset_active})
      `CHK("order", 1'(c), third_pole_cap_enable)
    end
    wr(`PLF_ADDR_CTRL, 8'h03);
    $display("test phase done");
    img = {8'($urandom), 32'($urandom)};
    nv_image = img;
    @(negedge clk_sys);
    {reg_wr, reg_rd, nonvolatile_load_trigger} = 3'b001;
    @(negedge clk_sys);
    // A read in the copy cycle is refused: no note, so any answer is a mismatch
    {nonvolatile_load_trigger, reg_rd, reg_addr} = {2'b01, `PLF_ADDR_R2};
    `CHK("busy", 1'b1, load_busy)
    idle(1);
    `CHK("idle", 1'b0, load_busy)
    rd_all(img);
    // Trigger held into the copy cycle is remembered and copies a second time
    img = {8'($urandom), 32'($urandom)};
    nv_image = ~img;
    @(negedge clk_sys) nonvolatile_load_trigger = 1;
    repeat (2) @(negedge clk_sys);
    {nonvolatile_load_trigger, nv_image} = {1'b0, img};
    `CHK("again", 1'b0, load_busy)
    @(negedge clk_sys);
    `CHK("again2", 1'b1, load_busy)
    idle(1);
    rd_all(img);
    `CHK("drain", 0, exp_q.size())
    $display("test reload done");
    conclude;
  end
endmodule // test_plf_config_regs
